// [dv/iba_arbiter_asserts.sv]
`timescale 1ns/1ps
`include "iba_consts.vh"
// ************
// Port checks
// ************
module iba_arbiter_asserts (
   input wire        i_clk,
   input wire        i_rst_b,
   input wire        i_hsel,
   input wire [31:0] i_haddr,
   input wire [1:0]  i_htrans,
   input wire        i_hwrite,
   input wire [31:0] i_hwdata,
   input wire        i_hready,
   input wire        i_int_ack_n,
   input wire        o_irq_out_n,
   input wire [7:0]  o_int_bus_n,
   input wire        o_evaluate_hold_strobe,
   input wire [7:0]  o_current_interrupt_snapshot,
   input wire        o_grx_rd,
   input wire [1:0]  o_gq_chan
);
   wire [7:0] win  = ~o_int_bus_n;
   wire [7:0] snap = o_current_interrupt_snapshot;
   wire       ev   = o_evaluate_hold_strobe;
   wire       take = i_hsel && i_htrans[1] && i_hready;
   reg        cmd_q;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cmd_q <= 1'b0;
      end else begin
         cmd_q <= take && i_hwrite && (i_haddr[7:0] == `IBA_A_CMD);
      end
   end
   no_bid_idle_a: assert property (o_int_bus_n == 8'hFF |=> o_irq_out_n)
      else $error("request with no bid");
   type_nonzero_a: assert property (o_int_bus_n != 8'hFF |-> win[4:2] != 3'b000)
      else $error("winner without type");
   tx_msb_low_a: assert property (win[4:2] == 3'b010 |-> !win[7])
      else $error("transmit bid msb set");
   timer_chan_a: assert property (win[4:2] == 3'b101 |-> win[0] && !win[5])
      else $error("timer bid channel wrong");
   latch_edge_a: assert property ($changed(o_int_bus_n) |-> $fell(ev))
      else $error("bus latch off strobe edge");
   eval_high_a: assert property ($rose(ev) |-> ev [*8])
      else $error("evaluate phase too short");
   eval_low_a: assert property ($fell(ev) |-> !ev [*8])
      else $error("hold phase too short");
   irq_cause_a: assert property (!o_irq_out_n |-> $past(o_int_bus_n) != 8'hFF)
      else $error("request without winner");
   snap_hold_a: assert property ($changed(snap) |-> $past(cmd_q && i_hwdata[0])
      || !$past(i_int_ack_n) || !$past(i_int_ack_n, 2))
      else $error("snapshot moved without capture");
   gchan_follow_a: assert property ($changed(snap) |-> o_gq_chan ==
      (($past(win) == 8'h00) ? 2'b11 : $past(win[1:0])))
      else $error("global channel differs");
   grx_pulse_a: assert property (take && !i_hwrite && i_haddr[7:0] == `IBA_A_GRX
      |=> o_grx_rd)
      else $error("global read not steered");
endmodule
bind iba_arbiter iba_arbiter_asserts iba_arbiter_asserts_inst (.i_clk, .i_rst_b, .i_hsel,
   .i_haddr, .i_htrans, .i_hwrite, .i_hwdata, .i_hready, .i_int_ack_n, .o_irq_out_n,
   .o_int_bus_n, .o_evaluate_hold_strobe, .o_current_interrupt_snapshot, .o_grx_rd,
   .o_gq_chan);

// [dv/iba_host_model.sv]
`timescale 1ns/1ps
// ************
// Host acknowledge pulses
// ************
module iba_host_model (
   input  wire       i_clk,
   input  wire       i_rst_b,
   input  wire       i_ack_req,
   input  wire [3:0] i_ack_len,
   output reg        o_int_ack_n
);
   reg [3:0] cnt_q;
   // Four cycles at least, so the pin synchroniser can never miss a pulse
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_q       <= 4'h0;
         o_int_ack_n <= 1'b1;
      end else if (cnt_q != 4'h0) begin
         cnt_q       <= cnt_q - 4'h1;
         o_int_ack_n <= (cnt_q == 4'h1);
      end else if (i_ack_req) begin
         cnt_q       <= (i_ack_len < 4'h4) ? 4'h4 : i_ack_len;
         o_int_ack_n <= 1'b0;
      end
   end
endmodule

// [dv/testbench.sv]
`timescale 1ns/1ps
`include "iba_consts.vh"
module testbench;
   // ************
   // Design, host and clock
   // ************
   reg         i_clk, i_rst_b, i_hsel, i_hwrite, ack_req;
   reg  [31:0] i_haddr, i_hwdata, i_rx_data, r1, r2, r3, rd;
   reg  [15:0] i_rx_count, i_tx_free;
   reg  [3:0]  i_rx_error_flag, i_break_det, i_pin_change_detect, ack_len;
   reg  [2:0]  i_hsize;
   reg  [1:0]  i_htrans, i_ct_event;
   reg  [17:0] mask;
   reg  [7:0]  w, thr, snap;
   wire        i_int_ack_n, o_hreadyout, o_hresp, o_irq_out_n, o_vector_en;
   wire        o_evaluate_hold_strobe, o_grx_rd, o_gtx_wr, i_hready;
   wire [31:0] o_hrdata;
   wire [7:0]  o_vector, o_int_bus_n, o_current_interrupt_snapshot, o_gtx_data;
   wire [1:0]  o_gq_chan;
   integer     num_errors, samples_checked, seed, it;
   // The one slave's ready is the bus's ready
   assign i_hready = o_hreadyout;
   iba_arbiter iba_arbiter_inst (.i_clk, .i_rst_b, .i_hsel, .i_haddr, .i_htrans, .i_hwrite,
      .i_hsize, .i_hwdata, .i_hready, .o_hrdata, .o_hreadyout, .o_hresp, .i_rx_count,
      .i_rx_error_flag, .i_tx_free, .i_break_det, .i_pin_change_detect, .i_ct_event,
      .i_rx_data, .i_int_ack_n, .o_irq_out_n, .o_vector, .o_vector_en, .o_int_bus_n,
      .o_evaluate_hold_strobe, .o_current_interrupt_snapshot, .o_grx_rd, .o_gtx_wr,
      .o_gq_chan, .o_gtx_data);
   iba_host_model iba_host_model_inst (.i_clk, .i_rst_b, .i_ack_req(ack_req),
      .i_ack_len(ack_len), .o_int_ack_n(i_int_ack_n));
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   // ************
   // Expectation, bus and checks
   // ************
   function automatic [7:0] exp_win(input [17:0] m, input [27:0] p);
      integer   c;
      reg [7:0] best, b;
      reg [3:0] n;
      begin
         best = 8'h00;
         for (c = 0; c < 4; c = c + 1) begin
            n = i_rx_count[4*c+:4];
            b = {(n > 4'h7) ? 3'h7 : n[2:0], i_rx_error_flag[c], 2'b11, c[1:0]};
            if (m[c] && n != 4'h0 && b > best) best = b;
            n = i_tx_free[4*c+:4];
            b = {1'b0, (n > 4'h3) ? 2'h3 : n[1:0], 3'b010, c[1:0]};
            if (m[4+c] && n != 4'h0 && b > best) best = b;
            b = {p[3*c+:3], 3'b100, c[1:0]};
            if (m[8+c] && i_break_det[c] && b > best) best = b;
            b = {p[12+3*c+:3], 3'b001, c[1:0]};
            if (m[12+c] && i_pin_change_detect[c] && b > best) best = b;
            b = {p[24+2*(c%2)+:2], 1'b0, 3'b101, c[0], 1'b1};
            if (c < 2 && m[16+c] && i_ct_event[c] && b > best) best = b;
         end
         exp_win = best;
      end
   endfunction
   function automatic [7:0] exp_vec(input [1:0] ivc, input [7:0] iv, input [7:0] wn);
      begin
         exp_vec = (ivc == 2'b01) ? {iv[7:2], wn[1:0]} :
                   (ivc == 2'b10) ? {iv[7:5], wn[4:0]} : iv;
      end
   endfunction
   task chk(input string nm, input [31:0] e, input [31:0] g);
      begin
         samples_checked = samples_checked + 1;
         if (g !== e) begin
            num_errors = num_errors + 1;
            $display("ERROR %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task ahb(input wr, input [7:0] a, input [31:0] wd);
      begin
         @(posedge i_clk);
         i_hsel <= 1'b1;
         i_htrans <= 2'b10;
         i_hwrite <= wr;
         i_haddr <= {24'h000000, a};
         @(posedge i_clk);
         while (o_hreadyout !== 1'b1) @(posedge i_clk);
         i_hsel <= 1'b0;
         i_htrans <= 2'b00;
         i_hwdata <= wd;
         @(posedge i_clk);
         while (o_hreadyout !== 1'b1) @(posedge i_clk);
         rd = o_hrdata;
      end
   endtask
   task report_and_stop;
      begin
         $display("checks %0d errors %0d", samples_checked, num_errors);
         if (num_errors == 0 && samples_checked > 0) begin
            $display("bench passed");
         end else begin
            $display("bench failed");
         end
         $finish;
      end
   endtask
   initial begin
      repeat (40000) @(posedge i_clk);
      num_errors = num_errors + 1;
      $display("ERROR watchdog expected end seen timeout");
      report_and_stop;
   end
   // ************
   // Tests
   // ************
   initial begin
      seed = 32'hD9CD990B;
      {i_rst_b, i_hsel, i_hwrite, ack_req, i_htrans, i_ct_event, ack_len} = 0;
      {i_haddr, i_hwdata, i_rx_data, i_rx_count, i_tx_free} = 0;
      {i_rx_error_flag, i_break_det, i_pin_change_detect} = 0;
      i_hsize = 3'b010;
      num_errors = 0;
      samples_checked = 0;
      repeat (2) @(posedge i_clk);
      i_rst_b <= 1'b1;
      ahb(1'b1, `IBA_A_SNAP, 32'h00000000);
      ahb(1'b0, `IBA_A_SNAP, 32'h0);
      chk("snapshot", `IBA_RST_SNAP, rd);
      ahb(1'b0, `IBA_A_CTRL, 32'h0);
      chk("ctrl", `IBA_RST_CTRL, rd);
      ahb(1'b0, `IBA_A_IVR, 32'h0);
      chk("ivr", `IBA_RST_IVR, rd);
      ahb(1'b0, 8'h3C, 32'h0);
      chk("unmapped", 32'h0, rd);
      $display("test reset done");
      for (it = 0; it < 24; it = it + 1) begin
         r1 = (it == 1) ? 32'h0 : $random(seed);
         r2 = (it == 1) ? 32'h0 : $random(seed);
         r3 = $random(seed);
         mask = (it == 0) ? 18'h0 : (it == 1) ? 18'h3FFFF : r3[17:0];
         @(posedge i_clk);
         {i_tx_free, i_rx_count} <= r1;
         {i_ct_event, i_pin_change_detect, i_break_det, i_rx_error_flag} <= r2[13:0];
         i_rx_data <= $random(seed);
         r1 = $random(seed);
         ahb(1'b1, `IBA_A_MASK, {14'h0, mask});
         ahb(1'b1, `IBA_A_PRIO, {4'h0, r1[27:0]});
         ahb(1'b1, `IBA_A_IVR, {24'h0, r3[15:8]});
         w = exp_win(mask, r1[27:0]);
         thr = (it % 3 == 1) ? w : (it % 3 == 2) ? w - 8'h01 : r3[31:24];
         ahb(1'b1, `IBA_A_CTRL, {21'h0, it >= 18, r2[15:14], thr});
         repeat (3) @(posedge o_evaluate_hold_strobe);
         repeat (3) @(posedge i_clk);
         chk("int_bus_n", w ^ 8'hFF, o_int_bus_n);
         chk("irq_out_n", !(w > thr), o_irq_out_n);
         ahb(1'b0, `IBA_A_WIN, 32'h0);
         chk("winner", w, rd);
         chk("hresp", 32'h0, o_hresp);
         if (it % 2 == 1) begin
            ahb(1'b1, `IBA_A_CMD, 32'h1);
         end else begin
            ack_len <= 4'h4 + {1'b0, r3[22:20]};
            ack_req <= 1'b1;
            @(posedge i_clk);
            ack_req <= 1'b0;
            repeat (3) @(posedge i_clk);
            @(negedge i_clk);
            chk("vector_en", r2[15:14] != 2'b11, o_vector_en);
            if (r2[15:14] != 2'b11) chk("vector", exp_vec(r2[15:14], r3[15:8], w), o_vector);
            repeat (11) @(posedge i_clk);
            @(negedge i_clk);
            chk("vector_en", 32'h0, o_vector_en);
         end
         snap = (w == 8'h00) ? 8'hFF : w;
         ahb(1'b0, `IBA_A_SNAP, 32'h0);
         chk("snapshot", snap, rd);
         ahb(1'b0, `IBA_A_GCOUNT, 32'h0);
         chk("gcount", snap[7:5], rd);
         ahb(1'b0, `IBA_A_GCHAN, 32'h0);
         chk("gchan", snap[1:0], rd);
         ahb(1'b0, `IBA_A_GRX, 32'h0);
         chk("grx", i_rx_data[8*snap[1:0]+:8], rd);
         ahb(1'b1, `IBA_A_GTX, r3);
         @(negedge i_clk);
         chk("gtx_wr", 32'h1, o_gtx_wr);
         chk("gtx_data", r3[7:0], o_gtx_data);
         chk("gq_chan", snap[1:0], o_gq_chan);
         $display("test arbitration %0d done", it);
      end
      i_rst_b <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_rst_b <= 1'b1;
      ahb(1'b0, `IBA_A_SNAP, 32'h0);
      chk("snapshot", `IBA_RST_SNAP, rd);
      $display("test second reset done");
      report_and_stop;
   end
endmodule

// [rtl/iba_arbiter.v]
// Implementation choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`include "iba_consts.vh"

module iba_arbiter (
   // Clock and reset
   input  wire        i_clk,
   input  wire        i_rst_b,
   // AHB-Lite slave
   input  wire        i_hsel,
   input  wire [31:0] i_haddr,
   input  wire [1:0]  i_htrans,
   input  wire        i_hwrite,
   input  wire [2:0]  i_hsize,
   input  wire [31:0] i_hwdata,
   input  wire        i_hready,
   output wire [31:0] o_hrdata,
   output wire        o_hreadyout,
   output wire        o_hresp,
   // Interrupt sources
   input  wire [15:0] i_rx_count,
   input  wire [3:0]  i_rx_error_flag,
   input  wire [15:0] i_tx_free,
   input  wire [3:0]  i_break_det,
   input  wire [3:0]  i_pin_change_detect,
   input  wire [1:0]  i_ct_event,
   // Receive data of each channel
   input  wire [31:0] i_rx_data,
   // Host interrupt pins
   input  wire        i_int_ack_n,
   output wire        o_irq_out_n,
   output wire [7:0]  o_vector,
   output wire        o_vector_en,
   // Arbitration status
   output wire [7:0]  o_int_bus_n,
   output wire        o_evaluate_hold_strobe,
   output wire [7:0]  o_current_interrupt_snapshot,
   // Global queue access steering
   output wire        o_grx_rd,
   output wire        o_gtx_wr,
   output wire [1:0]  o_gq_chan,
   output wire [7:0]  o_gtx_data
);

   // ************************************************************
   // Functions
   // ************************************************************
   function [2:0] sat3;
      input [3:0] n;
      begin
         sat3 = (n > 4'h7) ? 3'h7 : n[2:0];
      end
   endfunction

   function [1:0] sat2;
      input [3:0] n;
      begin
         sat2 = (n > 4'h3) ? 2'h3 : n[1:0];
      end
   endfunction

   // Bitwise maximum search as done on a wired-OR bus
   function [7:0] max_bid;
      input [143:0] b;
      reg   [17:0]  alive;
      reg   [17:0]  hit;
      integer       bit_i;
      integer       s;
      begin
         alive = 18'h3FFFF;
         for (bit_i = 7; bit_i >= 0; bit_i = bit_i - 1) begin
            for (s = 0; s < 18; s = s + 1) begin
               hit[s] = alive[s] & b[s*8+bit_i];
            end
            if (|hit) begin
               alive = hit;
            end
         end
         max_bid = 8'h00;
         for (s = 0; s < 18; s = s + 1) begin
            if (alive[s]) begin
               max_bid = max_bid | b[s*8 +: 8];
            end
         end
      end
   endfunction

   // ************************************************************
   // Registers
   // ************************************************************
   reg  [10:0]  ctrl_q;
   reg  [17:0]  mask_q;
   reg  [27:0]  prio_q;
   reg  [7:0]   ivr_q;
   reg  [7:0]   snap_q;
   reg  [7:0]   win_q;
   reg          irq_q;
   reg  [7:0]   vec_q;
   reg          vec_en_q;
   reg  [5:0]   cnt_q;
   reg          div2_q;
   reg          inhibit_q;
   reg          ack_s1_q;
   reg          ack_s2_q;
   reg          ack_s3_q;
   reg  [31:0]  rdata_q;
   reg          dwr_q;
   reg  [7:0]   daddr_q;
   reg          grx_rd_q;
   reg          gtx_wr_q;
   reg  [7:0]   gtx_data_q;
   reg  [143:0] bids;
   integer      k;

   wire [7:0]  thr      = ctrl_q[`IBA_CTRL_THR_LSB +: 8];
   wire [1:0]  ivc      = ctrl_q[`IBA_CTRL_IVC_LSB +: 2];
   wire        div2     = ctrl_q[`IBA_CTRL_DIV2];
   wire [1:0]  snap_ch  = snap_q[1:0];
   wire        addr_ok  = i_hsel & i_htrans[1] & i_hready;
   wire [7:0]  aaddr    = i_haddr[7:0];
   wire        ack_fall = ack_s3_q & ~ack_s2_q;

   // ************************************************************
   // Bid formation
   // ************************************************************
   // Sources: 0-3 rx, 4-7 tx, 8-11 break, 12-15 change, 16-17 timers
   always @* begin
      bids = 144'h0;
      for (k = 0; k < 4; k = k + 1) begin
         if (mask_q[k] && i_rx_count[k*4 +: 4] != 4'h0) begin
            bids[k*8 +: 8] = {sat3(i_rx_count[k*4 +: 4]),
                              i_rx_error_flag[k],
                              `IBA_TYPE_RX,
                              k[1:0]};
         end
         if (mask_q[4+k] && i_tx_free[k*4 +: 4] != 4'h0) begin
            bids[(4+k)*8 +: 8] = {1'b0,
                                  sat2(i_tx_free[k*4 +: 4]),
                                  `IBA_TYPE_TX,
                                  k[1:0]};
         end
         if (mask_q[8+k] && i_break_det[k]) begin
            bids[(8+k)*8 +: 8] = {prio_q[k*3 +: 3],
                                  `IBA_TYPE_BRK,
                                  k[1:0]};
         end
         if (mask_q[12+k] && i_pin_change_detect[k]) begin
            bids[(12+k)*8 +: 8] = {prio_q[12+k*3 +: 3],
                                   `IBA_TYPE_COS,
                                   k[1:0]};
         end
      end
      if (mask_q[16] && i_ct_event[0]) begin
         bids[16*8 +: 8] = {prio_q[25:24], 1'b0, `IBA_TYPE_CT, `IBA_CH_CT_AB};
      end
      if (mask_q[17] && i_ct_event[1]) begin
         bids[17*8 +: 8] = {prio_q[27:26], 1'b0, `IBA_TYPE_CT, `IBA_CH_CT_CD};
      end
   end

   wire [7:0] bus_win = max_bid(bids);

   // ************************************************************
   // Evaluate/hold strobe
   // ************************************************************
   // One oscillator period is the arbitration period; divide-by-two doubles it
   // The divider is taken only at a period boundary, so no phase is cut short
   wire [5:0] period = div2_q ? `IBA_PERIOD_2X : `IBA_PERIOD_1X;
   wire [5:0] half   = {1'b0, period[5:1]};
   wire       eval   = (cnt_q < half);
   wire       trail  = (cnt_q == (half - 6'h01));
   wire       wrap   = (cnt_q == (period - 6'h01));

   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_q  <= 6'h00;
         div2_q <= 1'b0;
      end else if (wrap || cnt_q >= period) begin
         cnt_q  <= 6'h00;
         div2_q <= div2;
      end else begin
         cnt_q <= cnt_q + 6'h01;
      end
   end

   // ************************************************************
   // Bus latch, comparator and snapshot
   // ************************************************************
   wire upd_cmd = dwr_q && daddr_q == `IBA_A_CMD && i_hwdata[`IBA_CMD_UPDATE];

   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ack_s1_q  <= 1'b1;
         ack_s2_q  <= 1'b1;
         ack_s3_q  <= 1'b1;
         win_q     <= 8'h00;
         irq_q     <= 1'b0;
         inhibit_q <= 1'b0;
         snap_q    <= `IBA_RST_SNAP;
         vec_q     <= 8'h00;
         vec_en_q  <= 1'b0;
      end else begin
         ack_s1_q <= i_int_ack_n;
         ack_s2_q <= ack_s1_q;
         ack_s3_q <= ack_s2_q;
         // An inhibited evaluation keeps the latch steady for the capture
         if (trail) begin
            if (!inhibit_q) begin
               win_q <= bus_win;
            end
            inhibit_q <= 1'b0;
         end
         if (ack_fall && !eval) begin
            inhibit_q <= 1'b1;
         end
         irq_q <= (win_q > thr);
         if (ack_fall || upd_cmd) begin
            snap_q <= (win_q == 8'h00) ? `IBA_RST_SNAP : win_q;
         end
         vec_en_q <= ack_fall ? (ivc != 2'b11) : (vec_en_q & ~ack_s2_q);
         if (ack_fall) begin
            case (ivc)
               2'b01:   vec_q <= {ivr_q[7:2], win_q[1:0]};
               2'b10:   vec_q <= {ivr_q[7:5], win_q[4:0]};
               default: vec_q <= ivr_q;
            endcase
         end
      end
   end

   // ************************************************************
   // AHB-Lite slave
   // ************************************************************
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         dwr_q    <= 1'b0;
         daddr_q  <= 8'h00;
         rdata_q  <= 32'h0;
         grx_rd_q <= 1'b0;
      end else begin
         dwr_q    <= addr_ok & i_hwrite;
         daddr_q  <= aaddr;
         grx_rd_q <= 1'b0;
         rdata_q  <= 32'h0;
         // Read data is sampled in the address phase so no wait state is needed
         if (addr_ok && !i_hwrite) begin
            if (aaddr == `IBA_A_CTRL) begin
               rdata_q <= {21'h0, ctrl_q};
            end else if (aaddr == `IBA_A_MASK) begin
               rdata_q <= {14'h0, mask_q};
            end else if (aaddr == `IBA_A_PRIO) begin
               rdata_q <= {4'h0, prio_q};
            end else if (aaddr == `IBA_A_SNAP) begin
               rdata_q <= {24'h0, snap_q};
            end else if (aaddr == `IBA_A_GCOUNT) begin
               rdata_q <= {29'h0, snap_q[7:5]};
            end else if (aaddr == `IBA_A_GCHAN) begin
               rdata_q <= {30'h0, snap_ch};
            end else if (aaddr == `IBA_A_WIN) begin
               rdata_q <= {24'h0, win_q};
            end else if (aaddr == `IBA_A_IVR) begin
               rdata_q <= {24'h0, ivr_q};
            end else if (aaddr == `IBA_A_GRX) begin
               rdata_q  <= {24'h0, i_rx_data[snap_ch*8 +: 8]};
               grx_rd_q <= 1'b1;
            end
         end
      end
   end

   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ctrl_q     <= `IBA_RST_CTRL;
         mask_q     <= `IBA_RST_MASK;
         prio_q     <= `IBA_RST_PRIO;
         ivr_q      <= `IBA_RST_IVR;
         gtx_wr_q   <= 1'b0;
         gtx_data_q <= 8'h00;
      end else begin
         gtx_wr_q <= 1'b0;
         if (dwr_q) begin
            if (daddr_q == `IBA_A_CTRL) begin
               ctrl_q <= i_hwdata[10:0];
            end else if (daddr_q == `IBA_A_MASK) begin
               mask_q <= i_hwdata[17:0];
            end else if (daddr_q == `IBA_A_PRIO) begin
               prio_q <= i_hwdata[27:0];
            end else if (daddr_q == `IBA_A_IVR) begin
               ivr_q <= i_hwdata[7:0];
            end else if (daddr_q == `IBA_A_GTX) begin
               gtx_wr_q   <= 1'b1;
               gtx_data_q <= i_hwdata[7:0];
            end
         end
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign o_hrdata                     = rdata_q;
   assign o_hreadyout                  = 1'b1;
   assign o_hresp                      = 1'b0;
   assign o_irq_out_n                  = ~irq_q;
   assign o_vector                     = vec_q;
   assign o_vector_en                  = vec_en_q;
   assign o_int_bus_n                  = ~win_q;
   assign o_evaluate_hold_strobe       = eval;
   assign o_current_interrupt_snapshot = snap_q;
   assign o_grx_rd                     = grx_rd_q;
   assign o_gtx_wr                     = gtx_wr_q;
   assign o_gq_chan                    = snap_ch;
   assign o_gtx_data                   = gtx_data_q;

endmodule

// [rtl/iba_consts.vh]
`ifndef IBA_CONSTS_VH
`define IBA_CONSTS_VH

`define IBA_A_CTRL      8'h00
`define IBA_A_MASK      8'h04
`define IBA_A_PRIO      8'h08
`define IBA_A_SNAP      8'h0C
`define IBA_A_GCOUNT    8'h10
`define IBA_A_GCHAN     8'h14
`define IBA_A_CMD       8'h18
`define IBA_A_WIN       8'h1C
`define IBA_A_IVR       8'h20
`define IBA_A_GRX       8'h24
`define IBA_A_GTX       8'h28

`define IBA_CTRL_THR_LSB 0
`define IBA_CTRL_IVC_LSB 8
`define IBA_CTRL_DIV2    10
`define IBA_CMD_UPDATE   0

`define IBA_RST_CTRL    11'h0FF
`define IBA_RST_MASK    18'h00000
`define IBA_RST_PRIO    28'h0000000
`define IBA_RST_SNAP    8'hFF
`define IBA_RST_IVR     8'h0F

`define IBA_TYPE_RX     2'b11
`define IBA_TYPE_TX     3'b010
`define IBA_TYPE_BRK    3'b100
`define IBA_TYPE_COS    3'b001
`define IBA_TYPE_CT     3'b101
`define IBA_CH_CT_AB    2'b01
`define IBA_CH_CT_CD    2'b11

`define IBA_CLK_PERIOD_NS 10
`define IBA_OSC_PERIOD_NS 250
// Strobe period in clocks: one oscillator period, doubled with the divider
`define IBA_PERIOD_1X     6'h19
`define IBA_PERIOD_2X     6'h32

`endif
